//--- dv/bcfs_channel_test.sv
// Self-checking testbench for the buck channel fault sequencer.
`timescale 1ns/1ns
`define CHK(a,b) begin n_tests++; if ((a) !== (b)) begin fails++; $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
`define WAITC(c) begin for (int k = 0; k < 400 && !(c); k++) step(1); \
    if (!(c)) `CHK(1'b0, 1'b1) end
module bcfs_channel_test;
    logic                   CLK, RESET_N, ON_COMMAND, DIE_HOT, DIE_COOL;
    logic                   PWM_CYCLE_START, PWM_DUTY_END, ext_pull;
    logic                   PWM_OUT, PWM_OE, PWM_MID, POWER_GOOD_OUT;
    logic                   FS_OE, SOFT_START_ACTIVE, hs_on, ls_on, fs_wire;
    bcfs_pkg::bcfs_cfg_t    CFG;
    bcfs_pkg::bcfs_meas_t   MEAS;
    bcfs_pkg::bcfs_status_t STATUS_CLEAR, STATUS;
    logic                   ctl_pin, m_retry;
    int                     fails, n_tests;
    int                     cyc = 0;

    bcfs_channel #(.PG_DELAY_CYCLES(20)) i_dut (
        .CLK(CLK), .RESET_N(RESET_N), .CE(1'b1), .CFG(CFG),
        .MASTER_OC_RETRY(m_retry), .MEAS(MEAS),
        .ON_COMMAND(ON_COMMAND), .CHANNEL_CONTROL_PIN(ctl_pin),
        .PWM_CYCLE_START(PWM_CYCLE_START), .PWM_DUTY_END(PWM_DUTY_END),
        .DIE_HOT(DIE_HOT), .DIE_COOL(DIE_COOL), .FAULT_SHARE_PIN_IN(fs_wire),
        .STATUS_CLEAR(STATUS_CLEAR), .PWM_OUT(PWM_OUT), .PWM_OE(PWM_OE),
        .PWM_MID(PWM_MID), .POWER_GOOD_OUT(POWER_GOOD_OUT),
        .FAULT_SHARE_PIN_OUT(), .FAULT_SHARE_PIN_OE(FS_OE), .SS_REF(),
        .SOFT_START_ACTIVE(SOFT_START_ACTIVE), .STATUS(STATUS));

    bcfs_stage_model i_stage (.pwm_out(PWM_OUT), .pwm_oe(PWM_OE),
        .pwm_mid(PWM_MID), .fs_oe(FS_OE), .ext_pull(ext_pull),
        .hs_on(hs_on), .ls_on(ls_on), .fs_wire(fs_wire));

    initial
    begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    task automatic step(input int n);
        repeat (n) @(posedge CLK);
        #2;
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic clear_all();
        STATUS_CLEAR = '1;
        step(1);
        STATUS_CLEAR = '0;
    endtask

    task automatic restart();
        ON_COMMAND = 1'b0;
        step(12);
        ON_COMMAND = 1'b1;
        `WAITC(SOFT_START_ACTIVE)
        `WAITC(!SOFT_START_ACTIVE)
    endtask

    // PWM period of 8 cycles keeps the overcurrent count short.
    always @(posedge CLK)
    begin
        cyc <= cyc + 1;
        PWM_CYCLE_START <= #2 (cyc % 8 == 0);
        PWM_DUTY_END <= #2 (cyc % 8 == 4);
        if (cyc > 30000)
        begin
            fails++;
            conclude();
        end
    end

    initial
    begin
        fails = 0; n_tests = 0; RESET_N = 1'b0; ON_COMMAND = 1'b0;
        ctl_pin = 1'b0;
        m_retry = 1'b0;
        DIE_HOT = 1'b0; DIE_COOL = 1'b1; ext_pull = 1'b0; STATUS_CLEAR = '0;
        PWM_CYCLE_START = 1'b0; PWM_DUTY_END = 1'b0;
        CFG = '0;
        CFG.use_cmd = 1'b1;
        CFG.on_delay = 24'h3;
        CFG.off_delay = 24'h3;
        CFG.ss_time = 24'ha;
        MEAS = {12'h600, 12'h600, 12'h500, 12'h700, 12'h400, 12'h800,
                12'h800, 12'h100, 12'h800, 12'h700, 12'h100, 12'h800,
                12'h700, 12'h600, 12'h900, 12'h300, 12'h200};
        step(3);
        RESET_N = 1'b1;
        ON_COMMAND = 1'b1;
        step(4);
        `CHK(SOFT_START_ACTIVE, 1'b0)
        step(1);
        `CHK(SOFT_START_ACTIVE, 1'b1)
        `CHK(POWER_GOOD_OUT, 1'b0)
        `WAITC(!SOFT_START_ACTIVE)
        step(10);
        `CHK(POWER_GOOD_OUT, 1'b0)
        step(20);
        `CHK(POWER_GOOD_OUT, 1'b1)
        MEAS.feedback_sense = 12'h4f0;
        step(2);
        `CHK(POWER_GOOD_OUT, 1'b0)
        CFG.pg_no_delay = 1'b1;
        MEAS.feedback_sense = 12'h600;
        step(2);
        `CHK(POWER_GOOD_OUT, 1'b1)
        CFG.pg_no_delay = 1'b0;
        $display("test power good done");
        MEAS.current_peak = 12'hf00;
        `WAITC(STATUS.oc_fault)
        `CHK(STATUS.oc_fault, 1'b1)
        MEAS.current_peak = 12'h100;
        step(2);
        `CHK(FS_OE, 1'b1)
        `CHK({hs_on, ls_on}, 2'b00)
        step(150);
        `CHK({SOFT_START_ACTIVE, FS_OE}, 2'b01)
        clear_all();
        `CHK(STATUS.oc_fault, 1'b0)
        restart();
        CFG.oc_retry = 1'b1;
        MEAS.current_peak = 12'hf00;
        `WAITC(STATUS.oc_fault)
        MEAS.current_peak = 12'h100;
        clear_all();
        `WAITC(SOFT_START_ACTIVE)
        `CHK(SOFT_START_ACTIVE, 1'b1)
        `WAITC(!SOFT_START_ACTIVE)
        $display("test overcurrent done");
        ON_COMMAND = 1'b0;
        `WAITC(PWM_MID)
        `CHK({PWM_MID, PWM_OE}, 2'b11)
        step(1);
        `CHK(PWM_MID, 1'b0)
        restart();
        MEAS.feedback_sense = 12'h900;
        `WAITC(STATUS.ov_fault)
        MEAS.feedback_sense = 12'h600;
        step(8);
        `CHK({hs_on, ls_on}, 2'b01)
        restart();
        clear_all();
        $display("test turn-off and overvoltage done");
        CFG.is_slave = 1'b1;
        MEAS.feedback_sense = 12'h300;
        step(10);
        `CHK(STATUS.uv_fault, 1'b0)
        MEAS.feedback_sense = 12'h600;
        MEAS.current_peak = 12'hf00;
        `WAITC(STATUS.oc_fault)
        MEAS.current_peak = 12'h100;
        step(150);
        `CHK({FS_OE, STATUS.ext_fault}, 2'b10)
        CFG.is_slave = 1'b0;
        restart();
        ext_pull = 1'b1;
        step(4);
        `CHK(STATUS.ext_fault, 1'b1)
        `CHK({hs_on, ls_on}, 2'b00)
        ext_pull = 1'b0;
        restart();
        DIE_HOT = 1'b1;
        DIE_COOL = 1'b0;
        step(4);
        `CHK(STATUS.tsd_fault, 1'b1)
        `CHK({hs_on, ls_on}, 2'b00)
        DIE_HOT = 1'b0;
        DIE_COOL = 1'b1;
        `WAITC(SOFT_START_ACTIVE)
        `CHK(SOFT_START_ACTIVE, 1'b1)
        CFG.use_pin = 1'b1;
        step(30);
        `CHK(PWM_OE, 1'b0)
        ctl_pin = 1'b1;
        `WAITC(SOFT_START_ACTIVE)
        `CHK(SOFT_START_ACTIVE, 1'b1)
        CFG.use_vin = 1'b1;
        MEAS.vin = 12'h100;
        step(3);
        `CHK({STATUS.vin_uv, FS_OE}, 2'b11)
        MEAS.vin = 12'h280;
        step(3);
        `CHK(STATUS.vin_uv, 1'b1)
        MEAS.vin = 12'h900;
        `WAITC(SOFT_START_ACTIVE)
        `CHK(SOFT_START_ACTIVE, 1'b1)
        $display("test slave and temperature done");
        conclude();
    end
endmodule

//--- dv/bcfs_chk_asserts.sv
// Port-level assertions for the buck channel fault sequencer.
`timescale 1ns/1ns
module bcfs_chk_asserts #(
    parameter int PG_DELAY_CYCLES = 20
) (
    input wire logic                   CLK,
    input wire logic                   RESET_N,
    input wire logic                   CE,
    input wire bcfs_pkg::bcfs_cfg_t    CFG,
    input wire bcfs_pkg::bcfs_meas_t   MEAS,
    input wire bcfs_pkg::bcfs_status_t STATUS_CLEAR,
    input wire logic                   PWM_OUT,
    input wire logic                   PWM_OE,
    input wire logic                   PWM_MID,
    input wire logic                   POWER_GOOD_OUT,
    input wire logic                   FAULT_SHARE_PIN_OE,
    input wire logic                   SOFT_START_ACTIVE,
    input wire bcfs_pkg::bcfs_status_t STATUS
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    AST_PG_SOFT: assert property (SOFT_START_ACTIVE |=> !POWER_GOOD_OUT)
        else $error("power good high in soft-start");
    AST_PG_DROP: assert property (CE && MEAS.feedback_sense
        < MEAS.pg_window_floor |=> !POWER_GOOD_OUT)
        else $error("power good not dropped below window");
    AST_MID_ONE: assert property (CE && PWM_MID |=> !PWM_MID)
        else $error("mid level held too long");
    AST_MID_NDRV: assert property (PWM_MID |-> PWM_OE)
        else $error("mid level not driven");
    AST_OC_SHARE: assert property ($rose(STATUS.oc_fault)
        |-> ##[0:2] FAULT_SHARE_PIN_OE)
        else $error("fault share not pulled on overcurrent");
    AST_STICKY: assert property (CE && STATUS.oc_fault
        && !STATUS_CLEAR.oc_fault |=> STATUS.oc_fault)
        else $error("overcurrent flag lost without clear");
    AST_OV_LOW: assert property ($rose(STATUS.ov_fault)
        |-> ##[1:3] (PWM_OE && !PWM_OUT))
        else $error("low side not held on overvoltage");
    AST_SLAVE: assert property (CFG.is_slave && !STATUS.uv_fault
        && !STATUS.ov_fault |=> !STATUS.uv_fault && !STATUS.ov_fault)
        else $error("slave flagged output voltage fault");
    AST_SS_OC: assert property (SOFT_START_ACTIVE && $past(SOFT_START_ACTIVE)
        && !STATUS.oc_fault |=> !STATUS.oc_fault)
        else $error("counted overcurrent during soft-start");
endmodule

bind bcfs_channel bcfs_chk_asserts #(.PG_DELAY_CYCLES(PG_DELAY_CYCLES)) i_chk (
    .CLK(CLK), .RESET_N(RESET_N), .CE(CE), .CFG(CFG), .MEAS(MEAS),
    .STATUS_CLEAR(STATUS_CLEAR), .PWM_OUT(PWM_OUT), .PWM_OE(PWM_OE),
    .PWM_MID(PWM_MID), .POWER_GOOD_OUT(POWER_GOOD_OUT),
    .FAULT_SHARE_PIN_OE(FAULT_SHARE_PIN_OE),
    .SOFT_START_ACTIVE(SOFT_START_ACTIVE), .STATUS(STATUS));

//--- dv/bcfs_stage_model.sv
// Behavioural power stage and fault-share wire.
`timescale 1ns/1ns
module bcfs_stage_model (
    input  wire logic pwm_out,
    input  wire logic pwm_oe,
    input  wire logic pwm_mid,
    input  wire logic fs_oe,
    input  wire logic ext_pull,
    output logic      hs_on,
    output logic      ls_on,
    output logic      fs_wire
);
    // A floating or mid-level pin turns both switches off.
    assign hs_on = pwm_oe && pwm_out && !pwm_mid;
    assign ls_on = pwm_oe && !pwm_out && !pwm_mid;
    // Open-drain wire with pull-up: any party may pull it low.
    assign fs_wire = !(fs_oe || ext_pull);
endmodule

//--- inc/bcfs_pkg.sv
// Package with types and constants for the buck channel fault sequencer.
package bcfs_pkg;

    localparam int    CLK_PERIOD_NS    = 20;
    localparam int    MID_DRIVE_NS     = 20;
    localparam int    MID_DRIVE_CYC    = (MID_DRIVE_NS + CLK_PERIOD_NS - 1)
                                         / CLK_PERIOD_NS;
    localparam int    PG_DELAY_MS      = 2;
    localparam int    PG_DELAY_CYC     = PG_DELAY_MS * 1000000 / CLK_PERIOD_NS;
    localparam int    OC_COUNT_LIMIT   = 7;
    localparam int    RETRY_RISE_MULT  = 7;
    localparam int    VW               = 12;
    localparam int    TW               = 24;
    localparam int    SS_MAX           = 12'hfff;

    typedef enum logic [1:0] {
        BCFS_PWM_LOW,
        BCFS_PWM_HIGH,
        BCFS_PWM_TRI
    } bcfs_pwm_t;

    typedef enum logic [2:0] {
        BCFS_OFF,
        BCFS_ON_WAIT,
        BCFS_SOFT,
        BCFS_RUN,
        BCFS_OFF_WAIT,
        BCFS_HICCUP,
        BCFS_LATCH
    } bcfs_state_t;

    // Channel configuration, normally from the management interface.
    typedef struct packed {
        logic          use_cmd;
        logic          use_pin;
        logic          use_vin;
        logic          is_slave;
        logic          oc_retry;
        logic          ov_tracking;
        logic          pg_no_delay;
        logic [TW-1:0] on_delay;
        logic [TW-1:0] off_delay;
        logic [TW-1:0] ss_time;
    } bcfs_cfg_t;

    // Digitised measurements and programmed limits.
    typedef struct packed {
        logic [VW-1:0] feedback_sense;
        logic [VW-1:0] reference;
        logic [VW-1:0] pg_window_floor;
        logic [VW-1:0] pg_window_ceiling;
        logic [VW-1:0] uv_threshold;
        logic [VW-1:0] ov_fixed_threshold;
        logic [VW-1:0] ov_track_threshold;
        logic [VW-1:0] current_peak;
        logic [VW-1:0] overcurrent_fault_threshold;
        logic [VW-1:0] overcurrent_warn_threshold;
        logic [VW-1:0] ext_temp;
        logic [VW-1:0] overtemp_fault_threshold;
        logic [VW-1:0] overtemp_warn_threshold;
        logic [VW-1:0] overtemp_hyst_threshold;
        logic [VW-1:0] vin;
        logic [VW-1:0] input_start_threshold;
        logic [VW-1:0] input_stop_threshold;
    } bcfs_meas_t;

    // Status flags, sticky until cleared by software; vin_uv follows the input.
    typedef struct packed {
        logic oc_warn;
        logic oc_fault;
        logic uv_fault;
        logic ov_fault;
        logic ot_warn;
        logic ot_fault;
        logic tsd_fault;
        logic vin_uv;
        logic ext_fault;
    } bcfs_status_t;

    localparam int STATUS_W = $bits(bcfs_status_t);

endpackage

//--- logic/bcfs_channel.sv
// One buck channel: start/stop sequencing, power-good and fault handling.
`timescale 1ns/1ns
// What this block does
// - PWM high, low or tri-state drives switches.
// - Entering tri-state drives mid level 20 ns.
// - Command, pin or input voltage gates start.
// - Programmable turn-on and turn-off delays.
// - New turn-on only once fully off.
// - Pre-bias: switching waits ramp reaching feedback.
// - Power-good held low during soft-start.
// - Power-good rises 2 ms after window entry.
// - Power-good drops at once outside window.
// - Peak current over limit ends pulse.
// - Seven overcurrent events in row shut down.
// - Soft-start overcurrent only limits each cycle.
// - Overcurrent action latches or retries after 7 rises.
// - Slave channel uses channel-one overcurrent action.
// - Undervoltage tracks; overvoltage fixed or tracking.
// - Undervoltage shuts off, after soft-start, like overcurrent.
// - Overvoltage holds low side on, latched.
// - Fixed overvoltage always on; tracking after soft-start.
// - Only master channel checks output voltage faults.
// - External overtemperature stops, retries below hysteresis.
// - Die overtemperature stops, restarts with soft-start.
// - Input thresholds come from programmed settings.
// - Faults except overvoltage pull fault-share low; external low stops.
module bcfs_channel #(
    parameter int PG_DELAY_CYCLES = bcfs_pkg::PG_DELAY_CYC
) (
    input  wire logic                   CLK,
    input  wire logic                   RESET_N,
    input  wire logic                   CE,
    input  wire bcfs_pkg::bcfs_cfg_t    CFG,
    input  wire logic                   MASTER_OC_RETRY,
    input  wire bcfs_pkg::bcfs_meas_t   MEAS,
    input  wire logic                   ON_COMMAND,
    input  wire logic                   CHANNEL_CONTROL_PIN,
    input  wire logic                   PWM_CYCLE_START,
    input  wire logic                   PWM_DUTY_END,
    input  wire logic                   DIE_HOT,
    input  wire logic                   DIE_COOL,
    input  wire logic                   FAULT_SHARE_PIN_IN,
    input  wire bcfs_pkg::bcfs_status_t STATUS_CLEAR,
    output logic                        PWM_OUT,
    output logic                        PWM_OE,
    output logic                        PWM_MID,
    output logic                        POWER_GOOD_OUT,
    output logic                        FAULT_SHARE_PIN_OUT,
    output logic                        FAULT_SHARE_PIN_OE,
    output logic [bcfs_pkg::VW-1:0]     SS_REF,
    output logic                        SOFT_START_ACTIVE,
    output bcfs_pkg::bcfs_status_t      STATUS
);
    typedef struct packed {
        bcfs_pkg::bcfs_state_t  st;
        logic [bcfs_pkg::TW-1:0] cnt;
        logic [bcfs_pkg::TW-1:0] ss_cnt;
        logic [bcfs_pkg::VW-1:0] ss_ref;
        logic                   switching;
        logic [2:0]             oc_run;
        logic                   oc_seen;
        logic [23:0]            pg_cnt;
        logic                   pg;
        logic                   ov_latch;
        logic                   ot_hold;
        logic                   tsd_hold;
        logic                   pin_prev;
        logic                   cmd_prev;
        logic                   pulse_on;
        bcfs_pkg::bcfs_status_t status;
    } bcfs_ch_t;

    bcfs_ch_t s_r;
    bcfs_ch_t s_nxt;

    bcfs_pkg::bcfs_pwm_t pwm_level;
    logic                enable_req;
    logic                vin_ok;
    logic                oc_over;
    logic                oc_warn_over;
    logic                uv_now;
    logic                ov_now;
    logic                ov_armed;
    logic                in_window;
    logic                ot_now;
    logic                oc_retry_eff;
    logic                toggle;
    logic                shut_fault;
    logic                after_ss;
    logic [bcfs_pkg::VW-1:0] ov_thr;

    function automatic logic above(input logic [bcfs_pkg::VW-1:0] v,
                                   input logic [bcfs_pkg::VW-1:0] t);
        above = (v > t);
    endfunction

    assign after_ss     = (s_r.st == bcfs_pkg::BCFS_RUN);
    // Input UVLO with hysteresis from the two programmed levels.
    assign vin_ok       = s_r.status.vin_uv
                          ? above(MEAS.vin, MEAS.input_start_threshold)
                          : !above(MEAS.input_stop_threshold, MEAS.vin);
    assign enable_req   = (!CFG.use_cmd || ON_COMMAND)
                          && (!CFG.use_pin || CHANNEL_CONTROL_PIN)
                          && (!CFG.use_vin || vin_ok);
    assign oc_over      = above(MEAS.current_peak,
                                MEAS.overcurrent_fault_threshold);
    assign oc_warn_over = above(MEAS.current_peak,
                                MEAS.overcurrent_warn_threshold);
    assign ov_thr       = CFG.ov_tracking ? MEAS.ov_track_threshold
                                          : MEAS.ov_fixed_threshold;
    assign ov_armed     = !CFG.is_slave
                          && (!CFG.ov_tracking || after_ss);
    assign ov_now       = ov_armed && above(MEAS.feedback_sense, ov_thr);
    assign uv_now       = !CFG.is_slave && after_ss
                          && above(MEAS.uv_threshold,
                                   MEAS.feedback_sense);
    assign in_window    = !above(MEAS.pg_window_floor, MEAS.feedback_sense)
                          && !above(MEAS.feedback_sense,
                                    MEAS.pg_window_ceiling);
    assign ot_now       = above(MEAS.ext_temp, MEAS.overtemp_fault_threshold);
    assign oc_retry_eff = CFG.is_slave ? MASTER_OC_RETRY : CFG.oc_retry;
    assign toggle       = (s_r.pin_prev && !CHANNEL_CONTROL_PIN)
                          || (s_r.cmd_prev && !ON_COMMAND);
    assign shut_fault   = !FAULT_SHARE_PIN_IN || s_r.ot_hold
                          || s_r.tsd_hold || (CFG.use_vin && !vin_ok);

    always_comb
    begin
        s_nxt          = s_r;
        s_nxt.pin_prev = CHANNEL_CONTROL_PIN;
        s_nxt.cmd_prev = ON_COMMAND;

        // Sticky flags: a new event wins over a clear in the same cycle.
        s_nxt.status = s_r.status & ~STATUS_CLEAR;
        s_nxt.status.vin_uv = CFG.use_vin && !vin_ok;
        if (oc_warn_over)
            s_nxt.status.oc_warn = 1'b1;
        if (above(MEAS.ext_temp, MEAS.overtemp_warn_threshold))
            s_nxt.status.ot_warn = 1'b1;
        // Our own pull-down on the shared wire is not an external fault.
        if (!FAULT_SHARE_PIN_IN && !FAULT_SHARE_PIN_OE)
            s_nxt.status.ext_fault = 1'b1;

        // Over-temperature holds release on their own recovery levels.
        if (ot_now)
        begin
            s_nxt.ot_hold         = 1'b1;
            s_nxt.status.ot_fault = 1'b1;
        end
        else if (!above(MEAS.ext_temp, MEAS.overtemp_hyst_threshold))
        begin
            s_nxt.ot_hold = 1'b0;
        end
        if (DIE_HOT)
        begin
            s_nxt.tsd_hold         = 1'b1;
            s_nxt.status.tsd_fault = 1'b1;
        end
        else if (DIE_COOL)
        begin
            s_nxt.tsd_hold = 1'b0;
        end

        // Pulse gating: a pulse ends early on peak overcurrent.
        if (PWM_CYCLE_START)
        begin
            s_nxt.pulse_on = s_r.switching;
            s_nxt.oc_seen  = 1'b0;
        end
        else if (PWM_DUTY_END || oc_over)
        begin
            s_nxt.pulse_on = 1'b0;
        end
        if (oc_over && s_r.pulse_on)
            s_nxt.oc_seen = 1'b1;

        case (s_r.st)
            bcfs_pkg::BCFS_OFF:
            begin
                s_nxt.switching = 1'b0;
                s_nxt.ss_ref    = '0;
                s_nxt.oc_run    = 3'h0;
                if (enable_req && !shut_fault && !s_r.ov_latch)
                begin
                    s_nxt.st  = bcfs_pkg::BCFS_ON_WAIT;
                    s_nxt.cnt = CFG.on_delay;
                end
            end
            bcfs_pkg::BCFS_ON_WAIT:
            begin
                if (!enable_req || shut_fault)
                    s_nxt.st = bcfs_pkg::BCFS_OFF;
                else if (s_r.cnt == '0)
                begin
                    s_nxt.st     = bcfs_pkg::BCFS_SOFT;
                    s_nxt.ss_cnt = '0;
                end
                else
                    s_nxt.cnt = s_r.cnt - 1'b1;
            end
            bcfs_pkg::BCFS_SOFT, bcfs_pkg::BCFS_RUN:
            begin
                if (s_r.st == bcfs_pkg::BCFS_SOFT)
                begin
                    // Linear reference ramp toward the set point.
                    s_nxt.ss_cnt = s_r.ss_cnt + 1'b1;
                    s_nxt.ss_ref = bcfs_pkg::VW'(
                        ({12'h0, MEAS.reference} * s_r.ss_cnt)
                        / (CFG.ss_time | 24'h1));
                    if (!above(MEAS.feedback_sense, s_r.ss_ref))
                        s_nxt.switching = 1'b1;
                    if (s_r.ss_cnt >= CFG.ss_time)
                    begin
                        s_nxt.st     = bcfs_pkg::BCFS_RUN;
                        s_nxt.ss_ref = MEAS.reference;
                        s_nxt.switching = 1'b1;
                    end
                end
                // Counted overcurrent only outside soft-start.
                if (PWM_CYCLE_START && s_r.st == bcfs_pkg::BCFS_RUN)
                    s_nxt.oc_run = s_r.oc_seen ? s_r.oc_run + 3'h1
                                               : 3'h0;
                if (s_r.st == bcfs_pkg::BCFS_RUN && PWM_CYCLE_START
                    && s_r.oc_seen
                    && s_r.oc_run == 3'(bcfs_pkg::OC_COUNT_LIMIT - 1))
                begin
                    s_nxt.status.oc_fault = 1'b1;
                    s_nxt.st  = oc_retry_eff ? bcfs_pkg::BCFS_HICCUP
                                             : bcfs_pkg::BCFS_LATCH;
                    s_nxt.cnt = bcfs_pkg::TW'(bcfs_pkg::RETRY_RISE_MULT
                                              * CFG.ss_time);
                end
                else if (uv_now)
                begin
                    s_nxt.status.uv_fault = 1'b1;
                    s_nxt.st  = oc_retry_eff ? bcfs_pkg::BCFS_HICCUP
                                             : bcfs_pkg::BCFS_LATCH;
                    s_nxt.cnt = bcfs_pkg::TW'(bcfs_pkg::RETRY_RISE_MULT
                                              * CFG.ss_time);
                end
                else if (shut_fault)
                    s_nxt.st = bcfs_pkg::BCFS_OFF;
                else if (!enable_req)
                begin
                    s_nxt.st  = bcfs_pkg::BCFS_OFF_WAIT;
                    s_nxt.cnt = CFG.off_delay;
                end
            end
            bcfs_pkg::BCFS_OFF_WAIT:
            begin
                // Turn-on requests are ignored until fully off.
                if (shut_fault || s_r.cnt == '0)
                    s_nxt.st = bcfs_pkg::BCFS_OFF;
                else
                    s_nxt.cnt = s_r.cnt - 1'b1;
            end
            bcfs_pkg::BCFS_HICCUP:
            begin
                s_nxt.switching = 1'b0;
                if (s_r.cnt == '0)
                    s_nxt.st = bcfs_pkg::BCFS_OFF;
                else
                    s_nxt.cnt = s_r.cnt - 1'b1;
            end
            bcfs_pkg::BCFS_LATCH:
            begin
                s_nxt.switching = 1'b0;
                if (toggle)
                    s_nxt.st = bcfs_pkg::BCFS_OFF;
            end
            default:
                s_nxt.st = bcfs_pkg::BCFS_OFF;
        endcase

        if (s_nxt.st == bcfs_pkg::BCFS_OFF)
            s_nxt.switching = 1'b0;

        // Overvoltage latch overrides all, cleared only by a toggle.
        if (ov_now)
        begin
            s_nxt.ov_latch        = 1'b1;
            s_nxt.status.ov_fault = 1'b1;
            s_nxt.st              = bcfs_pkg::BCFS_OFF;
            s_nxt.switching       = 1'b0;
        end
        else if (toggle)
            s_nxt.ov_latch = 1'b0;

        // Power-good: low in soft-start, delayed rise, instant fall.
        if (s_r.st != bcfs_pkg::BCFS_RUN || !in_window)
        begin
            s_nxt.pg     = 1'b0;
            s_nxt.pg_cnt = '0;
        end
        else if (CFG.pg_no_delay
                 || s_r.pg_cnt >= 24'(PG_DELAY_CYCLES - 1))
            s_nxt.pg = 1'b1;
        else
            s_nxt.pg_cnt = s_r.pg_cnt + 24'h1;
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            s_r          <= '0;
            s_r.st       <= bcfs_pkg::BCFS_OFF;
        end
        else if (CE)
        begin
            s_r <= s_nxt;
        end
    end

    always_comb
    begin
        if (s_r.ov_latch)
            pwm_level = bcfs_pkg::BCFS_PWM_LOW;
        else if (!s_r.switching)
            pwm_level = bcfs_pkg::BCFS_PWM_TRI;
        else
            pwm_level = s_r.pulse_on ? bcfs_pkg::BCFS_PWM_HIGH
                                     : bcfs_pkg::BCFS_PWM_LOW;
    end

    bcfs_pwm_out u_pwm (
        .clk     (CLK),
        .reset_n (RESET_N),
        .ce      (CE),
        .level   (pwm_level),
        .pin_out (PWM_OUT),
        .pin_oe  (PWM_OE),
        .pin_mid (PWM_MID)
    );

    // Open-drain fault share: drive low on temperature holds, input UV, hiccup or latch; not on overvoltage.
    assign FAULT_SHARE_PIN_OUT = 1'b0;
    assign FAULT_SHARE_PIN_OE  = s_r.ot_hold || s_r.tsd_hold
                                 || s_r.status.vin_uv
                                 || s_r.st == bcfs_pkg::BCFS_HICCUP
                                 || s_r.st == bcfs_pkg::BCFS_LATCH;
    assign POWER_GOOD_OUT      = s_r.pg;
    assign SS_REF              = s_r.ss_ref;
    assign SOFT_START_ACTIVE   = (s_r.st == bcfs_pkg::BCFS_SOFT);
    assign STATUS              = s_r.status;
endmodule

//--- logic/bcfs_pwm_out.sv
// Three-level PWM pin driver with a mid-level pulse before float.
`timescale 1ns/1ns
module bcfs_pwm_out (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic               ce,
    input  wire bcfs_pkg::bcfs_pwm_t level,
    output logic                    pin_out,
    output logic                    pin_oe,
    output logic                    pin_mid
);
    typedef struct packed {
        bcfs_pkg::bcfs_pwm_t prev;
        logic [3:0]          mid_cnt;
        logic                out;
        logic                oe;
        logic                mid;
    } bcfs_po_t;

    bcfs_po_t s_r;
    bcfs_po_t s_nxt;

    always_comb
    begin
        s_nxt      = s_r;
        s_nxt.prev = level;
        if (level == bcfs_pkg::BCFS_PWM_TRI)
        begin
            // Entering tri-state: drive mid level briefly, then release.
            if (s_r.prev != bcfs_pkg::BCFS_PWM_TRI)
            begin
                s_nxt.mid_cnt = 4'(bcfs_pkg::MID_DRIVE_CYC);
            end
            else if (s_r.mid_cnt != 4'h0)
            begin
                s_nxt.mid_cnt = s_r.mid_cnt - 4'h1;
            end
            s_nxt.mid = (s_nxt.mid_cnt != 4'h0);
            s_nxt.oe  = s_nxt.mid;
            s_nxt.out = 1'b0;
        end
        else
        begin
            s_nxt.mid_cnt = 4'h0;
            s_nxt.mid     = 1'b0;
            s_nxt.oe      = 1'b1;
            s_nxt.out     = (level == bcfs_pkg::BCFS_PWM_HIGH);
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_r <= '{bcfs_pkg::BCFS_PWM_TRI, 4'h0, 1'b0, 1'b0, 1'b0};
        end
        else if (ce)
        begin
            s_r <= s_nxt;
        end
    end

    assign pin_out = s_r.out;
    assign pin_oe  = s_r.oe;
    assign pin_mid = s_r.mid;
endmodule
